//--- bsfs_deglitch.sv
/*
  Deglitch filter: output rises only after the input held high for LEN cycles,
  falls as soon as the input drops. Input is taken synchronous.
*/
`default_nettype none

module bsfs_deglitch #(
  parameter int unsigned LEN = 2500
)(
  input  wire logic clk,   // core clock
  input  wire logic rst,   // synchronous reset
  input  wire logic din,   // raw condition
  output logic      dout   // filtered condition
);

  localparam int unsigned W = $clog2(LEN + 1);

  initial
  begin
    if (LEN < 1) $error("bsfs_deglitch: LEN must be at least 1");
  end

  logic [W-1:0] run_q;

  always_ff @(posedge clk)
  begin
    if (rst || !din)
    begin
      run_q <= '0;
      dout  <= 1'b0;
    end
    else if (run_q == W'(LEN - 1))
    begin
      dout <= 1'b1;
    end
    else
    begin
      run_q <= run_q + 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- bsfs_host_model.sv
/*
  Management host model: config writes, read addressing, restart command.
  Assumes bench tasks drive it after reset release.
*/
`default_nettype none

module bsfs_host_model (
  input  wire logic  clk,          // core clock
  output logic       restart_cmd,  // restart pulse
  output logic       reg_wr,       // write strobe
  output logic [7:0] reg_addr,     // command code
  output logic [7:0] reg_wdata     // write data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    restart_cmd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // address and data held until the edge that takes the strobe
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  task automatic peek(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
  endtask

  task automatic restart();
    @(posedge clk);
    restart_cmd <= 1'b1;
    @(posedge clk);
    restart_cmd <= 1'b0;
  endtask
endmodule

`default_nettype wire

//--- bsfs_pkg.sv
/*
  Package for the breaker startup and fault sequencer: timing constants,
  the self-check configuration register map, states and carrier structs.
  Assumes a 250 MHz core clock and comparator outputs already synchronous.
*/
// Functional notes
// [RQ1] Enable input honoured only after bias valid, address read, gate supply charged.
// [RQ2] Startup overcurrent threshold resets to 16A or 24A depending on variant.
// [RQ3] Gate supply ok, bias up and enable high start timed output discharge.
// [RQ4] By default the self-check starts as soon as gate supply and bias are ready. The code still waits in BSFS_WAIT_EN for enable.
// [RQ5] Output still high at check end latches fault, drops fault line and power good.
// [RQ6] Latched faults hold until enable toggle, input toggle or restart command.
// [RQ7] Self-check threshold picks one of four values from the config register.
// [RQ8] Output below threshold at check end passes and startup continues.
// [RQ9] Each restart discharges soft-start capacitor; still high after period latches fault.
// [RQ10] Overcurrent resistor checked continuously once bias valid; bad value latches fault.
// [RQ11] Soft-start ramp begins only after a passed self-check.
// [RQ12] No startup while bias undervoltage; bias watched at all times.
// [RQ13] Bias undervoltage shuts down; recovery resumes at the startup delay phase. The code restarts from BSFS_WAIT_BIAS if bias stays low over a cycle.
// [RQ14] After decoding, address pin becomes current hysteresis flag.
// [RQ15] Address resistor read after bias valid; out of range latches fault.
// [RQ16] After address fault, resistor reread on the second enable rise.
// [RQ17] Gate supply undervoltage checked while enabled, even before switch turns on.
// [RQ18] Gate drive undervoltage trips only after about 10 us deglitch.
// [RQ19] Gate supply and gate drive undervoltage latch switch off and fault line low.
// [RQ20] Gate drive undervoltage masked 100 ms during startup.
// [RQ21] After enable, programmable delay, then self-test and capacitor discharge, then ramp.
// [RQ22] Power good asserts when the ramp completes; normal operation follows.
// [RQ23] All fault sources merge into one latch; restart clears it and restarts.
// [RQ24] Check periods come from fixed counters; comparisons sampled once at expiry.
`default_nettype none

package bsfs_pkg;

  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned DEGLITCH_NS       = 10000;
  localparam int unsigned DEGLITCH_CYC      = (DEGLITCH_NS * CLK_MHZ) / 1000;
  localparam int unsigned VGS_MASK_MS       = 100;
  localparam int unsigned VGS_MASK_CYC      = VGS_MASK_MS * CLK_MHZ * 1000;
  localparam int unsigned SELF_CHECK_US     = 1000;
  localparam int unsigned SELF_CHECK_CYC    = SELF_CHECK_US * CLK_MHZ;
  localparam int unsigned SS_DISCH_US       = 500;
  localparam int unsigned SS_DISCH_CYC      = SS_DISCH_US * CLK_MHZ;
  localparam int unsigned START_DELAY_STEP_US = 1000;
  localparam int unsigned START_DELAY_STEP_CYC = START_DELAY_STEP_US * CLK_MHZ;

  localparam logic [7:0]  CFG_REG_ADDR      = 8'hD0;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  localparam int unsigned CFG_THR_LSB       = 0;   // self-check threshold select, 2 bits
  localparam int unsigned CFG_DLY_LSB       = 2;   // startup delay, 2 bits, steps
  localparam int unsigned CFG_ENWAIT_BIT    = 4;   // 1: self-check also waits for enable

  localparam logic [5:0]  OCP_START_16A     = 6'h10;
  localparam logic [5:0]  OCP_START_24A     = 6'h18;

  typedef enum logic [3:0] {
    BSFS_WAIT_BIAS  = 4'b0000,
    BSFS_READ_ADDR  = 4'b0001,
    BSFS_WAIT_EN    = 4'b0011,
    BSFS_DELAY      = 4'b0010,
    BSFS_SELF_CHECK = 4'b0110,
    BSFS_SS_DISCH   = 4'b0111,
    BSFS_RAMP       = 4'b0101,
    BSFS_RUN        = 4'b0100,
    BSFS_FAULT      = 4'b1100
  } bsfs_state_t;

  // analog comparator results, all synchronous and active high
  typedef struct packed {
    logic bias_ok;        // bias supply above its undervoltage level
    logic gate_supply_ok; // charge pump above its undervoltage level
    logic gate_drive_uv;  // gate drive below its undervoltage level
    logic vout_below;     // output under selected self-check threshold
    logic ss_below;       // soft-start capacitor under its threshold
    logic ocp_res_ok;     // overcurrent resistor in range
    logic addr_done;      // address resistor conversion finished
    logic addr_ok;        // address resistor in range
    logic ramp_done;      // output ramp complete
    logic above_hyst_hi;  // current above upper hysteresis level
    logic below_hyst_lo;  // current below lower hysteresis level
  } bsfs_sense_t;

  typedef struct packed {
    logic switch_on;      // pass switch gate enable
    logic out_discharge;  // active output discharge
    logic ss_discharge;   // soft-start capacitor discharge
    logic ss_charge;      // soft-start current source on
    logic addr_read;      // request an address resistor conversion
  } bsfs_drive_t;

endpackage

`default_nettype wire

//--- bsfs_sequencer.sv
/*
  Breaker startup and fault sequencer top. Holds the self-check config
  register, the startup state machine, the fault latch and the current
  hysteresis flag. Assumes comparator inputs synchronous to clk, and an
  external SMBus engine that presents decoded register writes and reads.
*/
`default_nettype none

module bsfs_sequencer
  import bsfs_pkg::*;
#(
  parameter bit          VARIANT_HI   = 1'b0,         // 0: 16A startup limit, 1: 24A
  parameter int unsigned VGS_MASK     = VGS_MASK_CYC,
  parameter int unsigned SELF_CHECK   = SELF_CHECK_CYC,
  parameter int unsigned SS_DISCH     = SS_DISCH_CYC,
  parameter int unsigned DELAY_STEP   = START_DELAY_STEP_CYC,
  parameter int unsigned DEGLITCH     = DEGLITCH_CYC
)(
  input  wire logic        clk,                     // 250 MHz core clock
  input  wire logic        rst,                     // bias-derived reset, high
  input  wire bsfs_sense_t sense,                   // comparator results
  input  wire logic        enable_undervolt_input,  // enable/input UVLO level
  input  wire logic        restart_cmd,             // restart command pulse
  input  wire logic        reg_wr,                  // register write strobe
  input  wire logic [7:0]  reg_addr,                // register command code
  input  wire logic [7:0]  reg_wdata,               // write data
  output logic [7:0]       reg_rdata,               // read data
  output bsfs_drive_t      drive,                   // analog controls
  output logic [1:0]       self_check_thr_sel,      // threshold select
  output logic [5:0]       startup_ocp_limit,       // startup limit, amps
  output logic             fault_n_out,             // fault line, low active
  output logic             fault_n_oe_n,            // fault pin drive, low drives
  output logic             power_good_output,       // power good
  output logic             address_select_pin_out,  // hysteresis flag
  output logic             address_select_pin_oe_n, // low once flag drives
  output bsfs_state_t      state                    // sequencer state
);

  initial
  begin
    if (VGS_MASK < 1 || SELF_CHECK < 1 || SS_DISCH < 1 || DELAY_STEP < 1)
      $error("bsfs_sequencer: timer lengths must be at least 1");
  end

  //////////////////////////////////////////////////////////////////////////////

  logic [7:0]  self_check_config_q;
  bsfs_state_t st_q;
  bsfs_state_t st_d;
  logic        en_q;
  logic        en_rise;
  logic        en_fall;
  logic        fault_q;
  logic        addr_fault_q;
  logic        addr_done_q;
  logic        addr_reread_q;
  logic [1:0]  en_rises_q;
  logic        restart;
  logic        vgs_filt;
  logic        chk_busy;
  logic        chk_done;
  logic        vgs_busy;
  logic        dly_busy;
  logic        dly_done;
  logic        chk_load;
  logic [31:0] chk_count;
  logic        vgs_load;
  logic        dly_load;
  logic        hyst_q;
  logic        trip;
  logic        bias_ready;
  logic        enabled;

  assign en_rise = enable_undervolt_input && !en_q;
  assign en_fall = !enable_undervolt_input && en_q;
  // an input-supply toggle shows up as a reset from the bias monitor
  assign restart = en_fall || restart_cmd; // RQ6

  always_ff @(posedge clk)
  begin
    if (rst) en_q <= 1'b0;
    else     en_q <= enable_undervolt_input;
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration register

  always_ff @(posedge clk)
  begin
    if (rst)
      self_check_config_q <= CFG_RESET;
    else if (reg_wr && reg_addr == CFG_REG_ADDR)
      self_check_config_q <= reg_wdata; // RQ7
  end

  always_comb
  begin
    reg_rdata = 8'h00;
    if (reg_addr == CFG_REG_ADDR)
      reg_rdata = self_check_config_q;
  end

  assign self_check_thr_sel = self_check_config_q[CFG_THR_LSB +: 2]; // RQ7
  assign startup_ocp_limit  = VARIANT_HI ? OCP_START_24A : OCP_START_16A; // RQ2

  //////////////////////////////////////////////////////////////////////////////
  // address resistor read and hysteresis flag

  always_ff @(posedge clk)
  begin
    if (rst || !sense.bias_ok)
    begin
      addr_done_q   <= 1'b0;
      addr_fault_q  <= 1'b0;
      addr_reread_q <= 1'b0;
      en_rises_q    <= 2'b00;
    end
    else
    begin
      if (addr_fault_q && en_rise && en_rises_q != 2'b10)
        en_rises_q <= en_rises_q + 2'b01;
      if (addr_fault_q && en_rise && en_rises_q == 2'b01)
      begin
        addr_reread_q <= 1'b1; // RQ16
        addr_done_q   <= 1'b0;
        addr_fault_q  <= 1'b0;
        en_rises_q    <= 2'b00;
      end
      else if (!addr_done_q && sense.addr_done)
      begin
        addr_done_q   <= 1'b1;
        addr_fault_q  <= !sense.addr_ok; // RQ15
        addr_reread_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      hyst_q <= 1'b0;
    else if (sense.above_hyst_hi)
      hyst_q <= 1'b1; // RQ14
    else if (sense.below_hyst_lo)
      hyst_q <= 1'b0; // RQ14
  end

  assign address_select_pin_out  = hyst_q;
  assign address_select_pin_oe_n = !(addr_done_q && !addr_fault_q); // RQ14

  //////////////////////////////////////////////////////////////////////////////
  // timers and filter

  bsfs_deglitch #(.LEN(DEGLITCH)) u_vgs_glitch (
    .clk  (clk),
    .rst  (rst),
    .din  (sense.gate_drive_uv),
    .dout (vgs_filt) // RQ18
  );

  // one timer serves both checks, which never overlap
  bsfs_timer #(.WIDTH(32)) u_chk_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (chk_load),
    .stop  (trip || restart),
    .count (chk_count),
    .busy  (chk_busy),
    .done  (chk_done)
  );

  bsfs_timer #(.WIDTH(32)) u_dly_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (dly_load),
    .stop  (trip || restart),
    .count (DELAY_STEP * (32'(self_check_config_q[CFG_DLY_LSB +: 2]) + 32'd1)),
    .busy  (dly_busy),
    .done  (dly_done)
  );

  bsfs_timer #(.WIDTH(32)) u_vgs_mask (
    .clk   (clk),
    .rst   (rst),
    .load  (st_q == BSFS_SS_DISCH && st_d == BSFS_RAMP),
    .stop  (1'b0),
    .count (32'(VGS_MASK)), // RQ20
    .busy  (vgs_busy),
    .done  ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // fault collection

  assign bias_ready = sense.bias_ok && addr_done_q && !addr_fault_q;
  assign enabled    = enable_undervolt_input && st_q != BSFS_WAIT_BIAS && st_q != BSFS_READ_ADDR;

  always_comb
  begin
    trip = 1'b0;
    if (st_q == BSFS_SELF_CHECK && chk_done && !sense.vout_below) trip = 1'b1; // RQ5 RQ24
    if (st_q == BSFS_SS_DISCH && chk_done && !sense.ss_below)     trip = 1'b1; // RQ9 RQ24
    if (sense.bias_ok && !sense.ocp_res_ok)                       trip = 1'b1; // RQ10
    if (sense.bias_ok && addr_done_q && addr_fault_q)             trip = 1'b1; // RQ15
    if (enabled && !sense.gate_supply_ok && st_q != BSFS_WAIT_EN) trip = 1'b1; // RQ17 RQ19
    if (vgs_filt && !vgs_busy && (st_q == BSFS_RAMP || st_q == BSFS_RUN)) trip = 1'b1; // RQ19 RQ20
  end

  // set wins over a same-cycle restart
  always_ff @(posedge clk)
  begin
    if (rst)
      fault_q <= 1'b0;
    else if (trip)
      fault_q <= 1'b1; // RQ23
    else if (restart)
      fault_q <= 1'b0; // RQ6 RQ23
  end

  //////////////////////////////////////////////////////////////////////////////
  // startup state machine

  always_comb
  begin
    st_d      = st_q;
    chk_load  = 1'b0;
    dly_load  = 1'b0;
    chk_count = 32'(SELF_CHECK);
    if (!sense.bias_ok)
      st_d = (st_q == BSFS_RUN || st_q == BSFS_RAMP) ? BSFS_WAIT_EN : BSFS_WAIT_BIAS; // RQ12 RQ13
    else if (trip || (fault_q && !restart))
      st_d = BSFS_FAULT;
    else if (restart && st_q > BSFS_READ_ADDR)
      st_d = BSFS_WAIT_EN; // RQ6
    else
    begin
      case (st_q)
        BSFS_WAIT_BIAS:
          st_d = BSFS_READ_ADDR;
        BSFS_READ_ADDR:
          if (bias_ready && sense.gate_supply_ok)
            st_d = BSFS_WAIT_EN; // RQ1
        BSFS_WAIT_EN:
          if (enable_undervolt_input) // RQ1 RQ21
          begin
            st_d     = BSFS_DELAY;
            dly_load = 1'b1;
          end
        BSFS_DELAY:
          if (dly_done && sense.gate_supply_ok &&
              (enable_undervolt_input || !self_check_config_q[CFG_ENWAIT_BIT])) // RQ3 RQ4
          begin
            st_d     = BSFS_SELF_CHECK;
            chk_load = 1'b1;
          end
        BSFS_SELF_CHECK:
          if (chk_done && sense.vout_below) // RQ8
          begin
            st_d      = BSFS_SS_DISCH;
            chk_load  = 1'b1;
            chk_count = 32'(SS_DISCH); // RQ9
          end
        BSFS_SS_DISCH:
          if (chk_done && sense.ss_below)
            st_d = BSFS_RAMP; // RQ11
        BSFS_RAMP:
          if (sense.ramp_done)
            st_d = BSFS_RUN; // RQ22
        BSFS_RUN:
          if (!enable_undervolt_input)
            st_d = BSFS_WAIT_EN;
        BSFS_FAULT:
          st_d = restart ? BSFS_WAIT_EN : BSFS_FAULT; // RQ23
        default:
          st_d = BSFS_WAIT_BIAS;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst) st_q <= BSFS_WAIT_BIAS;
    else     st_q <= st_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, registered

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive             <= '0;
      fault_n_out       <= 1'b0;
      fault_n_oe_n      <= 1'b1;
      power_good_output <= 1'b0;
    end
    else
    begin
      drive.switch_on     <= (st_d == BSFS_RAMP || st_d == BSFS_RUN); // RQ11 RQ19
      drive.out_discharge <= (st_d == BSFS_SELF_CHECK); // RQ3
      drive.ss_discharge  <= (st_d == BSFS_SS_DISCH); // RQ9
      drive.ss_charge     <= (st_d == BSFS_RAMP || st_d == BSFS_RUN);
      drive.addr_read     <= sense.bias_ok && !addr_done_q; // RQ15 RQ16
      fault_n_out         <= 1'b0;
      fault_n_oe_n        <= !(trip || (fault_q && !restart)); // RQ5 RQ23
      power_good_output   <= (st_d == BSFS_RUN) && !trip; // RQ5 RQ22
    end
  end

  assign state = st_q;

endmodule

`default_nettype wire

//--- bsfs_sequencer_properties.sv
/*
  Checker for the breaker startup and fault sequencer, top ports only.
  Assumes a bind from the bench file, one clock domain.
*/
`default_nettype none

module bsfs_sequencer_properties
  import bsfs_pkg::*;
#(
  parameter bit VARIANT_HI = 1'b0
)(
  input wire logic        clk,                     // core clock
  input wire logic        rst,                     // sync reset
  input wire bsfs_sense_t sense,                   // comparators
  input wire logic        enable_undervolt_input,  // enable level
  input wire logic        restart_cmd,             // restart pulse
  input wire logic        reg_wr,                  // write strobe
  input wire logic [7:0]  reg_addr,                // command code
  input wire logic [7:0]  reg_wdata,               // write data
  input wire logic [7:0]  reg_rdata,               // read data
  input wire bsfs_drive_t drive,                   // analog controls
  input wire logic [1:0]  self_check_thr_sel,      // threshold select
  input wire logic [5:0]  startup_ocp_limit,       // startup limit
  input wire logic        fault_n_out,             // fault line value
  input wire logic        fault_n_oe_n,            // fault pin drive
  input wire logic        power_good_output,       // power good
  input wire logic        address_select_pin_out,  // hysteresis flag
  input wire logic        address_select_pin_oe_n, // flag drive
  input wire bsfs_state_t state                    // sequencer state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  fault_pg_a : assert property (!fault_n_oe_n |-> !power_good_output)
    else $error("power good during fault");
  pg_rise_a : assert property ($rose(power_good_output) |-> $past(sense.ramp_done) || $past(sense.ramp_done, 2))
    else $error("power good rose without ramp done");
  switch_excl_a : assert property (drive.switch_on |-> !drive.out_discharge && !drive.ss_discharge)
    else $error("switch on during a discharge check");
  cfg_wr_a : assert property (reg_wr && reg_addr == CFG_REG_ADDR |=> self_check_thr_sel == $past(reg_wdata[1:0]))
    else $error("threshold select not written");
  rdata_zero_a : assert property (reg_addr != CFG_REG_ADDR |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  ocp_lim_a : assert property (startup_ocp_limit == (VARIANT_HI ? OCP_START_24A : OCP_START_16A))
    else $error("startup limit wrong");
  bias_hold_a : assert property (state == BSFS_WAIT_BIAS && !sense.bias_ok |=> state == BSFS_WAIT_BIAS)
    else $error("left bias wait without bias");
  addr_wait_a : assert property (state == BSFS_READ_ADDR && !sense.addr_done |=> state != BSFS_WAIT_EN)
    else $error("enable honoured before address read");
  fault_hold_a : assert property (!fault_n_oe_n && enable_undervolt_input && !restart_cmd |=> !fault_n_oe_n)
    else $error("fault released without restart");
  gs_trip_a : assert property (state == BSFS_RUN && enable_undervolt_input &&
    !sense.gate_supply_ok |-> ##[1:3] !fault_n_oe_n)
    else $error("gate supply undervoltage missed");

  cover property ($rose(power_good_output));
  cover property ($fell(fault_n_oe_n));
  cover property (state == BSFS_SS_DISCH);
endmodule

`default_nettype wire

//--- bsfs_sequencer_test.sv
/*
  Self-checking bench for the breaker sequencer with shortened counts.
  Assumes the host model and the property checker bound below.
*/
`default_nettype none

module bsfs_sequencer_test
  import bsfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam bsfs_sense_t GOOD = 11'h6F8;
  logic        clk;
  logic        rst;
  bsfs_sense_t sense;
  bsfs_sense_t s;
  logic        en;
  logic        restart_cmd;
  logic        reg_wr;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  bsfs_drive_t drive;
  logic [1:0]  thr_sel;
  logic [5:0]  ocp_lim;
  logic        fault_n_oe_n;
  logic        pg;
  bsfs_state_t state;
  int          bad_count;
  int          samples_checked;

  always #2 clk = ~clk;

  bsfs_host_model u_bsfs_host_model (.clk(clk), .restart_cmd(restart_cmd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  bsfs_sequencer #(.VGS_MASK(50), .SELF_CHECK(20), .SS_DISCH(20), .DELAY_STEP(5), .DEGLITCH(4))
  u_bsfs_sequencer (.clk(clk), .rst(rst), .sense(sense), .enable_undervolt_input(en),
    .restart_cmd(restart_cmd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .drive(drive), .self_check_thr_sel(thr_sel), .startup_ocp_limit(ocp_lim),
    .fault_n_out(), .fault_n_oe_n(fault_n_oe_n), .power_good_output(pg),
    .address_select_pin_out(), .address_select_pin_oe_n(), .state(state));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    samples_checked++;
    if (act !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    sense <= '0;
    en <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic apply(input bsfs_sense_t v, input logic e);
    @(posedge clk);
    sense <= v;
    en <= e;
  endtask

  task automatic wait_st(input bsfs_state_t t, input int lim);
    int n;
    n = 0;
    while (state !== t && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_flt(input logic v, input int lim);
    int n;
    n = 0;
    while (fault_n_oe_n !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic to_run();
    s = GOOD;
    s.ramp_done = 1'b1;
    do_reset();
    apply(s, 1'b1);
    wait_st(BSFS_RUN, 300);
    cmp8(8'(state), 8'(BSFS_RUN));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    int i;
    do_reset();
    u_bsfs_host_model.peek(CFG_REG_ADDR);
    @(negedge clk);
    cmp8(reg_rdata, CFG_RESET);
    cmp8({2'h0, ocp_lim}, {2'h0, OCP_START_16A});
    for (i = 0; i < 4; i++)
    begin
      u_bsfs_host_model.write_reg(CFG_REG_ADDR, 8'(i));
      @(negedge clk);
      cmp8({6'h0, thr_sel}, 8'(i));
    end
    u_bsfs_host_model.write_reg(8'h10, 8'hFF);
    @(negedge clk);
    cmp8(reg_rdata, 8'h00);
    cmp8({6'h0, thr_sel}, 8'h03);
  endtask

  task automatic t_start();
    s = GOOD;
    s.addr_done = 1'b0;
    do_reset();
    apply(s, 1'b1);
    repeat (10) @(negedge clk);
    cmp8(8'(state), 8'(BSFS_READ_ADDR));
    apply(GOOD, 1'b1);
    wait_st(BSFS_SELF_CHECK, 100);
    repeat (2) @(negedge clk);
    cmp8({7'h0, drive.out_discharge}, 8'h01);
    wait_st(BSFS_SS_DISCH, 100);
    repeat (2) @(negedge clk);
    cmp8({7'h0, drive.ss_discharge}, 8'h01);
    wait_st(BSFS_RAMP, 100);
    repeat (2) @(negedge clk);
    cmp8({7'h0, drive.switch_on}, 8'h01);
    s = GOOD;
    s.ramp_done = 1'b1;
    apply(s, 1'b1);
    wait_st(BSFS_RUN, 20);
    repeat (2) @(negedge clk);
    cmp8({7'h0, pg}, 8'h01);
    s.gate_supply_ok = 1'b0;
    apply(s, 1'b1);
    wait_flt(1'b0, 20);
    cmp8({7'h0, fault_n_oe_n}, 8'h00);
    s.gate_supply_ok = 1'b1;
    apply(s, 1'b1);
    repeat (10) @(negedge clk);
    cmp8({7'h0, fault_n_oe_n}, 8'h00);
    apply(s, 1'b0);
    wait_flt(1'b1, 20);
    cmp8({7'h0, fault_n_oe_n}, 8'h01);
  endtask

  task automatic t_selfcheck_fail();
    s = GOOD;
    s.vout_below = 1'b0;
    do_reset();
    apply(s, 1'b1);
    wait_flt(1'b0, 200);
    cmp8({6'h0, fault_n_oe_n, pg}, 8'h00);
    apply(GOOD, 1'b1);
    repeat (10) @(negedge clk);
    cmp8({7'h0, fault_n_oe_n}, 8'h00);
    u_bsfs_host_model.restart();
    wait_st(BSFS_RAMP, 300);
    cmp8(8'(state), 8'(BSFS_RAMP));
  endtask

  task automatic t_other_faults();
    s = GOOD;
    s.ss_below = 1'b0;
    do_reset();
    apply(s, 1'b1);
    wait_flt(1'b0, 200);
    cmp8({7'h0, fault_n_oe_n}, 8'h00);
    s = GOOD;
    s.addr_ok = 1'b0;
    do_reset();
    apply(s, 1'b0);
    wait_flt(1'b0, 50);
    cmp8({7'h0, fault_n_oe_n}, 8'h00);
    to_run();
    s.ocp_res_ok = 1'b0;
    apply(s, 1'b1);
    wait_flt(1'b0, 20);
    cmp8({7'h0, fault_n_oe_n}, 8'h00);
  endtask

  task automatic t_gate_drive();
    to_run();
    s.gate_drive_uv = 1'b1;
    apply(s, 1'b1);
    repeat (20) @(negedge clk);
    s.gate_drive_uv = 1'b0;
    apply(s, 1'b1);
    repeat (40) @(negedge clk);
    cmp8({7'h0, fault_n_oe_n}, 8'h01);
    s.gate_drive_uv = 1'b1;
    apply(s, 1'b1);
    s.gate_drive_uv = 1'b0;
    apply(s, 1'b1);
    repeat (10) @(negedge clk);
    cmp8({7'h0, fault_n_oe_n}, 8'h01);
    s.gate_drive_uv = 1'b1;
    apply(s, 1'b1);
    wait_flt(1'b0, 20);
    cmp8({7'h0, fault_n_oe_n}, 8'h00);
  endtask

  task automatic t_bias_loss();
    to_run();
    s.bias_ok = 1'b0;
    apply(s, 1'b1);
    repeat (3) @(negedge clk);
    cmp8({6'h0, pg, drive.switch_on}, 8'h00);
    s.bias_ok = 1'b1;
    apply(s, 1'b1);
    wait_st(BSFS_DELAY, 50);
    cmp8(8'(state), 8'(BSFS_DELAY));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    sense = '0;
    en = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    t_regs();
    t_start();
    t_selfcheck_fail();
    t_other_faults();
    t_gate_drive();
    t_bias_loss();
    summarize();
  end

  // a run is several hundred cycles
  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule

bind bsfs_sequencer bsfs_sequencer_properties #(.VARIANT_HI(VARIANT_HI)) u_bsfs_sequencer_properties (
  .clk(clk), .rst(rst), .sense(sense), .enable_undervolt_input(enable_undervolt_input),
  .restart_cmd(restart_cmd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .drive(drive), .self_check_thr_sel(self_check_thr_sel),
  .startup_ocp_limit(startup_ocp_limit), .fault_n_out(fault_n_out), .fault_n_oe_n(fault_n_oe_n),
  .power_good_output(power_good_output), .address_select_pin_out(address_select_pin_out),
  .address_select_pin_oe_n(address_select_pin_oe_n), .state(state));

`default_nettype wire

//--- bsfs_timer.sv
/*
  Down-counting one-shot timer: load starts it, done pulses once at expiry.
  Assumes load is a single-cycle request from the sequencer.
*/
`default_nettype none

module bsfs_timer
  import bsfs_pkg::*;
#(
  parameter int unsigned WIDTH = 32
)(
  input  wire logic             clk,   // core clock
  input  wire logic             rst,   // synchronous reset
  input  wire logic             load,  // start or restart
  input  wire logic             stop,  // abandon count
  input  wire logic [WIDTH-1:0] count, // cycles to run
  output logic                  busy,  // counting
  output logic                  done   // one-cycle expiry pulse
);

  initial
  begin
    if (WIDTH < 2) $error("bsfs_timer: WIDTH too small");
  end

  logic [WIDTH-1:0] cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst || stop)
    begin
      cnt_q <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else if (load)
    begin
      cnt_q <= count;
      busy  <= 1'b1;
      done  <= 1'b0;
    end
    else if (busy)
    begin
      cnt_q <= cnt_q - 1'b1;
      done  <= (cnt_q <= WIDTH'(1));
      busy  <= (cnt_q > WIDTH'(1));
    end
    else
    begin
      done <= 1'b0;
    end
  end

endmodule

`default_nettype wire
